// [iogp_regs.vh]
// Address map, field positions and timing constants of the I/O space block
`ifndef IOGP_REGS_VH
`define IOGP_REGS_VH

// Address ranges
`define IOGP_DATA_IO_BASE 8'h20
`define IOGP_SHORT_IO_LAST 8'h3f
`define IOGP_BIT_IO_LAST 8'h1f

// I/O addresses, bit-addressable range
`define IOGP_ADDR_SCR0 8'h1c
`define IOGP_ADDR_SCR1 8'h1d
`define IOGP_ADDR_SCR2 8'h1e
`define IOGP_ADDR_SCR3 8'h1f
`define IOGP_ADDR_FLAGS 8'h1b
`define IOGP_ADDR_EECTL 8'h1a

// I/O addresses above the bit range
`define IOGP_ADDR_EEDATA 8'h20
`define IOGP_ADDR_EEADRL 8'h21

// Extended I/O, data address 0x62
`define IOGP_ADDR_EEADRH 8'h42

// Control register fields
`define IOGP_EECTL_MODE_HI 5
`define IOGP_EECTL_MODE_LO 4
`define IOGP_EECTL_MWE 2
`define IOGP_EECTL_WE 1
`define IOGP_MODE_ATOMIC 2'h0
`define IOGP_MODE_RSVD 2'h3

// Reset values
`define IOGP_RST_BYTE 8'h00
`define IOGP_RST_MODE 2'h0

// Timing
`define IOGP_CLK_MHZ 100
`define IOGP_EE_ATOMIC_US 3400
`define IOGP_EE_SPLIT_US 1800
`define IOGP_MWE_CYC 3'h4

`endif

// [iogp_scratch.v]
// One general purpose storage register with masked write
`timescale 1ns/1ps
module iogp_scratch #(
  parameter W = 8
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire we_i,
  input wire [W-1:0] mask_i,
  input wire [W-1:0] val_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] store_q;
  reg [W-1:0] store_d;

  // Only the masked bits change
  always @* begin
    store_d = store_q;
    if (we_i) begin
      store_d = (store_q & ~mask_i) | (val_i & mask_i); // see RULE8
    end
  end

  // Cleared on reset, keeps any value
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      store_q <= {W{1'b0}}; // see RULE10
    end else begin
      store_q <= store_d;
    end
  end

  assign q_o = store_q;
endmodule

// [iogp_io_space.v]
// I/O space decode, bit access, flags, storage and EEPROM write control
//
// Contract
// RULE1 - All I/O registers reachable by data load/store
// RULE2 - Bit set/clear only for addresses 0x00-0x1F
// RULE3 - Bit tests with skip for low 32 addresses
// RULE4 - Short I/O access covers addresses 0x00-0x3F
// RULE5 - Data address equals I/O address plus 0x20
// RULE6 - Extended 0x60-0xFF by data load/store only
// RULE7 - Writing one clears flag, zero keeps it
// RULE8 - Bit instructions write only the addressed bit
// RULE9 - Software writes zero to reserved bits, addresses
// RULE10 - Four 8-bit storage registers, reset to zero
// RULE11 - Storage registers sit in bit-addressable range
// RULE12 - Running EEPROM write survives reset
// RULE13 - Busy flag clears after write time elapses
// RULE14 - One register per access, side-effect-free reads
`timescale 1ns/1ps
`include "iogp_regs.vh"
module iogp_io_space #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] EE_ATOMIC_CYC = `IOGP_EE_ATOMIC_US * `IOGP_CLK_MHZ,
  parameter [CNT_W-1:0] EE_SPLIT_CYC = `IOGP_EE_SPLIT_US * `IOGP_CLK_MHZ
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire data_load_instr_i,
  input wire data_store_instr_i,
  input wire [7:0] data_addr_i,
  input wire io_in_i,
  input wire io_out_i,
  input wire [5:0] io_addr_i,
  input wire set_io_bit_instr_i,
  input wire clear_io_bit_instr_i,
  input wire test_io_bit_instr_i,
  input wire skip_if_io_bit_one_i,
  input wire [4:0] bit_addr_i,
  input wire [2:0] bit_sel_i,
  input wire [7:0] wdata_i,
  input wire [7:0] flag_set_i,
  output reg [7:0] rdata_o,
  output reg rvalid_o,
  output reg skip_o,
  output reg err_o,
  output reg eeprom_write_strobe_o,
  output reg [8:0] ee_addr_o,
  output reg [7:0] ee_data_o,
  output wire [1:0] ee_mode_o,
  output wire ee_busy_o
);
  // Masked write of a plain register
  function [7:0] merge_bits;
    input [7:0] old;
    input [7:0] mask;
    input [7:0] val;
    begin
      merge_bits = (old & ~mask) | (val & mask);
    end
  endfunction

  // One-hot mask for a bit index
  function [7:0] bit_mask;
    input [2:0] sel;
    begin
      bit_mask = 8'h01 << sel;
    end
  endfunction

  reg acc_wr;
  reg acc_rd;
  reg acc_test;
  reg acc_bad;
  reg [7:0] acc_idx;
  reg [7:0] acc_mask;
  reg [7:0] acc_val;
  reg [7:0] rd_val;
  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg mwe_q;
  reg [2:0] mwe_cnt_q;
  reg busy_q;
  reg [CNT_W-1:0] ee_cnt_q;
  reg [1:0] mode_q;
  wire [7:0] scr_q [0:3];
  wire [3:0] sel_scr;
  wire sel_flags;
  wire sel_eectl;
  wire sel_eedata;
  wire sel_eeadrl;
  wire sel_eeadrh;
  wire mapped;
  wire wr_ok;
  wire [7:0] eectl_val;
  wire mode_wr;
  wire [1:0] mode_new;
  wire [7:0] eectl_merged;
  wire start_req;
  genvar gi;

  // Unify data, short I/O and bit accesses onto one I/O index
  always @* begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_test = 1'b0;
    acc_bad = 1'b0;
    acc_idx = 8'h00;
    acc_mask = 8'hff;
    acc_val = wdata_i;
    if (data_load_instr_i || data_store_instr_i) begin
      if (data_addr_i >= `IOGP_DATA_IO_BASE) begin
        acc_idx = data_addr_i - `IOGP_DATA_IO_BASE; // see RULE5
        acc_wr = data_store_instr_i; // see RULE1
        acc_rd = data_load_instr_i;
      end else begin
        acc_bad = 1'b1;
      end
    end else if (io_in_i || io_out_i) begin
      // Six address bits cannot reach the extended range
      acc_idx = {2'h0, io_addr_i}; // see RULE4
      acc_wr = io_out_i; // see RULE6
      acc_rd = io_in_i;
    end else if (set_io_bit_instr_i || clear_io_bit_instr_i) begin
      // Five address bits keep bit writes in the low range
      acc_idx = {3'h0, bit_addr_i}; // see RULE2
      acc_mask = bit_mask(bit_sel_i); // see RULE8
      acc_val = set_io_bit_instr_i ? 8'hff : 8'h00;
      acc_wr = 1'b1;
    end else if (test_io_bit_instr_i) begin
      acc_idx = {3'h0, bit_addr_i}; // see RULE3
      acc_mask = bit_mask(bit_sel_i);
      acc_test = 1'b1;
    end
  end

  // Address decode, each index selects at most one register
  assign sel_scr[0] = (acc_idx == `IOGP_ADDR_SCR0); // see RULE11
  assign sel_scr[1] = (acc_idx == `IOGP_ADDR_SCR1);
  assign sel_scr[2] = (acc_idx == `IOGP_ADDR_SCR2);
  assign sel_scr[3] = (acc_idx == `IOGP_ADDR_SCR3);
  assign sel_flags = (acc_idx == `IOGP_ADDR_FLAGS);
  assign sel_eectl = (acc_idx == `IOGP_ADDR_EECTL);
  assign sel_eedata = (acc_idx == `IOGP_ADDR_EEDATA);
  assign sel_eeadrl = (acc_idx == `IOGP_ADDR_EEADRL);
  assign sel_eeadrh = (acc_idx == `IOGP_ADDR_EEADRH);
  assign mapped = (|sel_scr) | sel_flags | sel_eectl | sel_eedata | sel_eeadrl | sel_eeadrh;
  assign wr_ok = acc_wr & mapped; // see RULE14

  // Four storage registers
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_scr
      iogp_scratch #(
        .W(8)
      ) u_scr (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .we_i(wr_ok & sel_scr[gi]),
        .mask_i(acc_mask),
        .val_i(acc_val),
        .q_o(scr_q[gi])
      );
    end
  endgenerate

  // Control register image, unused bits read zero
  assign eectl_val = {2'h0, mode_q, 1'b0, mwe_q, busy_q, 1'b0};

  // Read mux, no read changes any state
  always @* begin
    rd_val = 8'h00;
    if (sel_scr[0]) begin
      rd_val = scr_q[0]; // see RULE14
    end else if (sel_scr[1]) begin
      rd_val = scr_q[1];
    end else if (sel_scr[2]) begin
      rd_val = scr_q[2];
    end else if (sel_scr[3]) begin
      rd_val = scr_q[3];
    end else if (sel_flags) begin
      rd_val = flags_q;
    end else if (sel_eectl) begin
      rd_val = eectl_val;
    end else if (sel_eedata) begin
      rd_val = ee_data_o;
    end else if (sel_eeadrl) begin
      rd_val = ee_addr_o[7:0];
    end else if (sel_eeadrh) begin
      rd_val = {7'h00, ee_addr_o[8]};
    end
  end

  // Status flags, set wins over a same-cycle clear
  always @* begin
    flags_d = flags_q;
    if (wr_ok && sel_flags) begin
      flags_d = flags_q & ~(acc_val & acc_mask); // see RULE7
    end
    flags_d = flags_d | flag_set_i;
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      flags_q <= `IOGP_RST_BYTE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Answer to reads, bit tests and bad accesses
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= `IOGP_RST_BYTE;
      rvalid_o <= 1'b0;
      skip_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      rvalid_o <= acc_rd | acc_test;
      err_o <= acc_bad | ((acc_rd | acc_wr | acc_test) & ~mapped);
      if (acc_rd) begin
        rdata_o <= mapped ? rd_val : 8'h00;
      end
      if (acc_test) begin
        skip_o <= (|(rd_val & acc_mask)) == skip_if_io_bit_one_i; // see RULE3
      end else begin
        skip_o <= 1'b0;
      end
    end
  end

  // Master write enable, lapses after four cycles
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mwe_q <= 1'b0;
      mwe_cnt_q <= 3'h0;
    end else if (wr_ok && sel_eectl && acc_mask[`IOGP_EECTL_MWE]
                 && acc_val[`IOGP_EECTL_MWE]) begin
      mwe_q <= 1'b1;
      mwe_cnt_q <= `IOGP_MWE_CYC;
    end else if (mwe_cnt_q != 3'h0) begin
      mwe_cnt_q <= mwe_cnt_q - 3'h1;
      mwe_q <= (mwe_cnt_q != 3'h1);
    end else begin
      mwe_q <= 1'b0;
    end
  end

  // Mode change ignored while busy
  assign eectl_merged = merge_bits(eectl_val, acc_mask, acc_val);
  assign mode_new = eectl_merged[`IOGP_EECTL_MODE_HI:`IOGP_EECTL_MODE_LO];
  assign mode_wr = wr_ok & sel_eectl & ~busy_q
                   & (acc_mask[`IOGP_EECTL_MODE_HI] | acc_mask[`IOGP_EECTL_MODE_LO]);

  // Start only with master enable armed and a legal mode
  assign start_req = wr_ok & sel_eectl & acc_mask[`IOGP_EECTL_WE] & acc_val[`IOGP_EECTL_WE]
                     & mwe_q & ~busy_q & (mode_q != `IOGP_MODE_RSVD);

  // Write timer runs on through reset once started
  always @(posedge core_clk_i) begin
    if (busy_q) begin
      if (ee_cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0; // see RULE13
        ee_cnt_q <= {CNT_W{1'b0}};
      end else begin
        ee_cnt_q <= ee_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1}; // see RULE12
      end
    end else if (rst_i) begin
      busy_q <= 1'b0;
      ee_cnt_q <= {CNT_W{1'b0}};
      mode_q <= `IOGP_RST_MODE;
    end else if (start_req) begin
      busy_q <= 1'b1;
      ee_cnt_q <= (mode_q == `IOGP_MODE_ATOMIC) ? EE_ATOMIC_CYC : EE_SPLIT_CYC;
    end else if (mode_wr) begin
      mode_q <= mode_new;
    end
  end

  // Start pulse toward the EEPROM array
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      eeprom_write_strobe_o <= 1'b0;
    end else begin
      eeprom_write_strobe_o <= start_req;
    end
  end

  // Address and data, frozen during a write
  always @(posedge core_clk_i) begin
    if (busy_q) begin
      ee_addr_o <= ee_addr_o;
      ee_data_o <= ee_data_o;
    end else if (rst_i) begin
      ee_addr_o <= 9'h000;
      ee_data_o <= `IOGP_RST_BYTE;
    end else if (wr_ok) begin
      if (sel_eedata) begin
        ee_data_o <= merge_bits(ee_data_o, acc_mask, acc_val);
      end
      if (sel_eeadrl) begin
        ee_addr_o[7:0] <= merge_bits(ee_addr_o[7:0], acc_mask, acc_val);
      end
      if (sel_eeadrh) begin
        ee_addr_o[8] <= acc_mask[0] ? acc_val[0] : ee_addr_o[8];
      end
    end
  end

  assign ee_mode_o = mode_q;
  assign ee_busy_o = busy_q;
endmodule

// [iogp_chk.sv]
// Port timing checker of the I/O space block
`timescale 1ns/1ps
module iogp_chk #(
  parameter int EE_ATOMIC_CYC = 20
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire data_load_instr_i,
  input wire data_store_instr_i,
  input wire [7:0] data_addr_i,
  input wire io_in_i,
  input wire test_io_bit_instr_i,
  input wire [7:0] rdata_o,
  input wire rvalid_o,
  input wire skip_o,
  input wire err_o,
  input wire eeprom_write_strobe_o,
  input wire [8:0] ee_addr_o,
  input wire [7:0] ee_data_o,
  input wire [1:0] ee_mode_o,
  input wire ee_busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire rd_req = (data_load_instr_i && data_addr_i >= 8'h20) || io_in_i || test_io_bit_instr_i;
  wire quiet = !data_load_instr_i && !io_in_i && !test_io_bit_instr_i;
  sequence s_begin;
    $rose(ee_busy_o) ##0 eeprom_write_strobe_o;
  endsequence
  int busy_run = 0;
  always @(posedge core_clk_i) busy_run <= ee_busy_o ? busy_run + 1 : 0;
  AST_RD_ANSWER: assert property (rd_req |=> rvalid_o)
    else $error("read not answered");
  AST_NO_ANSWER: assert property (quiet |=> !rvalid_o)
    else $error("answer without read");
  AST_SKIP_CAUSE: assert property (skip_o |-> $past(test_io_bit_instr_i))
    else $error("skip without bit test");
  AST_LOW_ERR: assert property ((data_load_instr_i || data_store_instr_i) &&
    data_addr_i < 8'h20 |=> err_o) else $error("low data address accepted");
  AST_BUSY_RISE: assert property ($rose(ee_busy_o) |-> eeprom_write_strobe_o)
    else $error("busy without strobe");
  AST_BUSY_HOLD: assert property (s_begin |-> ee_busy_o [*8])
    else $error("busy dropped early");
  AST_BUSY_END: assert property (busy_run <= EE_ATOMIC_CYC)
    else $error("busy never dropped");
  AST_EE_FROZEN: assert property (ee_busy_o && $past(ee_busy_o) |-> $stable(ee_mode_o) &&
    $stable(ee_addr_o) && $stable(ee_data_o)) else $error("write setup changed while busy");
  AST_RST_OUT: assert property ($fell(rst_i) |-> rdata_o == 8'h00 && !rvalid_o && !err_o)
    else $error("outputs not cleared by reset");
endmodule
bind iogp_io_space iogp_chk #(.EE_ATOMIC_CYC(EE_ATOMIC_CYC)) i_iogp_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .data_load_instr_i(data_load_instr_i),
  .data_store_instr_i(data_store_instr_i), .data_addr_i(data_addr_i), .io_in_i(io_in_i),
  .test_io_bit_instr_i(test_io_bit_instr_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .skip_o(skip_o), .err_o(err_o), .eeprom_write_strobe_o(eeprom_write_strobe_o),
  .ee_addr_o(ee_addr_o), .ee_data_o(ee_data_o), .ee_mode_o(ee_mode_o), .ee_busy_o(ee_busy_o));

// [iogp_cpu.sv]
// Core-side model issuing load, store, short I/O and bit instructions
`timescale 1ns/1ps
module iogp_cpu (
  input wire core_clk_i,
  output logic ld_o = 1'b0,
  output logic st_o = 1'b0,
  output logic in_o = 1'b0,
  output logic out_o = 1'b0,
  output logic set_o = 1'b0,
  output logic clr_o = 1'b0,
  output logic tst_o = 1'b0,
  output logic one_o = 1'b0,
  output logic [7:0] daddr_o = 8'h00,
  output logic [5:0] ioaddr_o = 6'h00,
  output logic [4:0] baddr_o = 5'h00,
  output logic [2:0] sel_o = 3'h0,
  output logic [7:0] wd_o = 8'h00
);
  // One instruction per cycle, kind 8 is idle
  task op(input logic [3:0] k, input logic [7:0] a, input logic [2:0] s, input logic [7:0] w);
    ld_o = (k == 4'h0);
    st_o = (k == 4'h1);
    in_o = (k == 4'h2);
    out_o = (k == 4'h3);
    set_o = (k == 4'h4);
    clr_o = (k == 4'h5);
    tst_o = (k == 4'h6) || (k == 4'h7);
    one_o = (k == 4'h6);
    daddr_o = a;
    ioaddr_o = a[5:0];
    baddr_o = a[4:0];
    sel_o = s;
    wd_o = w;
    @(posedge core_clk_i);
    #1;
  endtask
endmodule

// [tb.sv]
// Self-checking bench of the I/O space block
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] flag_set_i = 8'h00;
  wire ld, st, in_w, out_w, set_w, clr_w, tst, one, rvalid_o, skip_o, err_o, strobe, ee_busy_o;
  wire [7:0] daddr, wd, rdata_o, ee_data_o;
  wire [5:0] ioaddr;
  wire [4:0] baddr;
  wire [2:0] sel;
  wire [8:0] ee_addr_o;
  wire [1:0] ee_mode_o;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  logic [7:0] v;
  logic [2:0] s;
  iogp_cpu i_iogp_cpu (.core_clk_i(core_clk_i), .ld_o(ld), .st_o(st), .in_o(in_w), .out_o(out_w),
    .set_o(set_w), .clr_o(clr_w), .tst_o(tst), .one_o(one), .daddr_o(daddr), .ioaddr_o(ioaddr),
    .baddr_o(baddr), .sel_o(sel), .wd_o(wd));
  iogp_io_space #(.EE_ATOMIC_CYC(20), .EE_SPLIT_CYC(10)) i_iogp_io_space (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .data_load_instr_i(ld), .data_store_instr_i(st),
    .data_addr_i(daddr), .io_in_i(in_w), .io_out_i(out_w), .io_addr_i(ioaddr),
    .set_io_bit_instr_i(set_w), .clear_io_bit_instr_i(clr_w), .test_io_bit_instr_i(tst),
    .skip_if_io_bit_one_i(one), .bit_addr_i(baddr), .bit_sel_i(sel), .wdata_i(wd),
    .flag_set_i(flag_set_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .skip_o(skip_o),
    .err_o(err_o), .eeprom_write_strobe_o(strobe), .ee_addr_o(ee_addr_o), .ee_data_o(ee_data_o),
    .ee_mode_o(ee_mode_o), .ee_busy_o(ee_busy_o));
  initial forever #5 core_clk_i = ~core_clk_i;
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 6000) begin
      mismatches++;
      wrap_up();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task rd(input logic [3:0] k, input logic [7:0] a, input logic [7:0] want);
    i_iogp_cpu.op(k, a, 3'h0, 8'h00);
    chk(rdata_o, want);
    chk({7'h0, rvalid_o}, 8'h01);
  endtask
  function automatic int exp_n(input logic [1:0] m);
    return (m == 2'h0) ? 20 : (m == 2'h3) ? 0 : 10;
  endfunction
  task ee_run(input logic [1:0] m, input bit r);
    i_iogp_cpu.op(4'h3, 8'h1a, 3'h0, {2'b00, m, 4'h4});
    i_iogp_cpu.op(4'h4, 8'h1a, 3'h1, 8'h00);
    chk({7'h0, strobe}, {7'h0, m != 2'h3});
    n = 0;
    while (ee_busy_o === 1'b1 && n < 100) begin
      if (r && n == 5) rst_i = 1'b1;
      if (r && n == 7) rst_i = 1'b0;
      i_iogp_cpu.op(4'h8, 8'h00, 3'h0, 8'h00);
      n++;
    end
    chk(8'(n), 8'(exp_n(m)));
    chk({6'h0, ee_mode_o}, {6'h0, m});
  endtask
  initial begin
    v = 8'($urandom(62444));
    repeat (6) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 4; i++) rd(4'h0, 8'h3c + i, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      i_iogp_cpu.op(4'h1, 8'h3c + i, 3'h0, v);
      rd(4'h2, 8'h1c + i, v);
      i_iogp_cpu.op(4'h3, 8'h1c + i, 3'h0, ~v);
      rd(4'h0, 8'h3c + i, ~v);
      s = 3'($urandom);
      i_iogp_cpu.op(4'h4, 8'h1c + i, s, 8'h00);
      rd(4'h2, 8'h1c + i, ~v | (8'h01 << s));
      i_iogp_cpu.op(4'h6, 8'h1c + i, s, 8'h00);
      chk({7'h0, skip_o}, 8'h01);
      i_iogp_cpu.op(4'h7, 8'h1c + i, s, 8'h00);
      chk({7'h0, skip_o}, 8'h00);
      i_iogp_cpu.op(4'h5, 8'h1c + i, s, 8'h00);
      i_iogp_cpu.op(4'h7, 8'h1c + i, s, 8'h00);
      chk({7'h0, skip_o}, 8'h01);
      rd(4'h2, 8'h1c + i, ~v & ~(8'h01 << s));
    end
    rd(4'h2, 8'h3f, 8'h00);
    i_iogp_cpu.op(4'h0, 8'h10, 3'h0, 8'h00);
    chk(rdata_o, 8'h00);
    chk({6'h0, err_o, rvalid_o}, 8'h02);
    i_iogp_cpu.op(4'h1, 8'h62, 3'h0, 8'h01);
    rd(4'h0, 8'h62, 8'h01);
    flag_set_i = 8'ha5;
    i_iogp_cpu.op(4'h8, 8'h00, 3'h0, 8'h00);
    flag_set_i = 8'h00;
    rd(4'h2, 8'h1b, 8'ha5);
    i_iogp_cpu.op(4'h3, 8'h1b, 3'h0, 8'h01);
    rd(4'h2, 8'h1b, 8'ha4);
    i_iogp_cpu.op(4'h3, 8'h1b, 3'h0, 8'h00);
    rd(4'h2, 8'h1b, 8'ha4);
    i_iogp_cpu.op(4'h4, 8'h1b, 3'h5, 8'h00);
    i_iogp_cpu.op(4'h5, 8'h1b, 3'h2, 8'h00);
    rd(4'h2, 8'h1b, 8'h84);
    flag_set_i = 8'h04;
    i_iogp_cpu.op(4'h3, 8'h1b, 3'h0, 8'h84);
    flag_set_i = 8'h00;
    rd(4'h2, 8'h1b, 8'h04);
    i_iogp_cpu.op(4'h3, 8'h21, 3'h0, 8'h5a);
    i_iogp_cpu.op(4'h3, 8'h20, 3'h0, 8'hc3);
    for (int j = 0; j < 4; j++) ee_run(2'(j + 1), j == 1);
    chk(ee_addr_o[7:0], 8'h5a);
    chk(ee_data_o, 8'hc3);
    rd(4'h2, 8'h1c, 8'h00);
    wrap_up();
  end
endmodule
